// ==== ioc_defs.svh ====
// ioc_defs.svh: offsets, reset values and field positions of the block
// assumes inclusion by the block's single design module and by the bench
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH

// register byte addresses on the apb word grid
`define IOC_ADDR_OPTION 8'h00
`define IOC_ADDR_CORE_INTERRUPT_CONTROL 8'h04
`define IOC_ADDR_PIE 8'h08
`define IOC_ADDR_PIR 8'h0c
`define IOC_ADDR_TIMER 8'h10
`define IOC_ADDR_PORT 8'h14

// reset values
`define IOC_OPTION_RESET 8'hff
`define IOC_CORE_INTERRUPT_CONTROL_RESET 8'h00
`define IOC_PIE_RESET 8'h00
`define IOC_PIR_RESET 8'h00

// pin vector layout after the synchronisers
`define IOC_PIN_EXT 7
`define IOC_PIN_TCK 6
`define IOC_PORT_MSB 5
`define IOC_PORT_LSB 0

`endif

// ==== ioc_pkg.sv ====
// ioc_pkg.sv: register layouts and the address decode type
// takes no numeric constants from ioc_defs.svh
package ioc_pkg;

  // option_config layout, bit 7 down to bit 0
  typedef struct packed {
    logic pullup_disable;
    logic ext_irq_edge_select;
    logic timer_clock_source;
    logic timer_source_edge;
    logic prescaler_assign;
    logic [2:0] prescaler_rate;
  } ioc_option_type;

  // core_interrupt_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic timer_overflow_enable;
    logic ext_irq_enable;
    logic port_change_enable;
    logic timer_overflow_flag;
    logic ext_irq_flag;
    logic port_change_flag;
  } ioc_core_interrupt_control_type;

  // register selected by the current apb address
  typedef enum logic [2:0] {
    IOC_SEL_OPTION,
    IOC_SEL_CORE_INTERRUPT_CONTROL,
    IOC_SEL_PIE,
    IOC_SEL_PIR,
    IOC_SEL_TIMER,
    IOC_SEL_PORT,
    IOC_SEL_NONE
  } ioc_sel_type;

endpackage : ioc_pkg

// ==== ioc_ctrl.sv ====
// ioc_ctrl.sv: interrupt gating, option register, event flags, apb slave
// assumes an apb master on pclk; ext, timer and port pins are asynchronous;
// instr_tick, wdt_tick and periph_set are one-cycle pulses on pclk
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "ioc_defs.svh"
module ioc_ctrl (
  // clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins
  input wire logic ext_irq_pin,
  input wire logic timer_clock_pin,
  input wire logic [5:0] port_pins,
  // port pull-up control
  input wire logic [5:0] port_latch,
  output logic [5:0] pullup_en,
  // same-clock event sources
  input wire logic instr_tick,
  input wire logic wdt_tick,
  input wire logic [7:0] periph_set,
  // results toward core and watchdog
  output logic irq_to_core,
  output logic wdt_prescaled_tick,
  output logic [7:0] timer_count
);

  // division mask: low bits that must all be ones for a prescaler hit
  function automatic logic [7:0] ioc_rate_mask(input logic [2:0] rate,
                                               input logic to_timer);
    logic [8:0] one_hot;
    one_hot = 9'h001 << ({1'b0, rate} + {3'b000, to_timer});
    return 8'(one_hot - 9'h001);
  endfunction : ioc_rate_mask

  // edge of a synchronised level, falling or rising as asked
  function automatic logic ioc_edge(input logic prev, input logic cur,
                                    input logic falling);
    return falling ? (prev & ~cur) : (~prev & cur);
  endfunction : ioc_edge

  ioc_pkg::ioc_option_type opt_q;
  ioc_pkg::ioc_option_type opt_d;
  ioc_pkg::ioc_core_interrupt_control_type intc_q;
  ioc_pkg::ioc_core_interrupt_control_type intc_d;
  ioc_pkg::ioc_core_interrupt_control_type intc_base_w;
  ioc_pkg::ioc_sel_type sel_w;
  logic [7:0] pie_q;
  logic [7:0] pie_d;
  logic [7:0] pir_q;
  logic [7:0] pir_d;
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic [1:0] prev_q;
  logic [5:0] last_read_q;
  logic [7:0] presc_q;
  logic [7:0] timer_q;
  logic [31:0] prdata_q;
  logic [5:0] pullup_q;
  logic irq_q;
  logic wdt_q;
  logic [7:0] rd_mux_w;
  logic [7:0] presc_mask_w;
  logic setup_w;
  logic access_w;
  logic wr_w;
  logic ext_edge_w;
  logic tck_edge_w;
  logic tmr_src_w;
  logic presc_event_w;
  logic presc_hit_w;
  logic tmr_inc_w;
  logic tmr_wr_w;
  logic rollover_w;
  logic mismatch_w;
  logic core_req_w;
  logic periph_req_w;
  logic irq_d;

  // apb phases; a freeze holds off the answer as well
  assign setup_w = psel & ~penable & ce;
  assign access_w = psel & penable & ce;
  assign wr_w = access_w & pwrite;
  assign pready = ce;
  assign pslverr = psel & penable & (sel_w == ioc_pkg::IOC_SEL_NONE);

  // address decode
  assign sel_w =
    (paddr == `IOC_ADDR_OPTION) ? ioc_pkg::IOC_SEL_OPTION :
    (paddr == `IOC_ADDR_CORE_INTERRUPT_CONTROL) ? ioc_pkg::IOC_SEL_CORE_INTERRUPT_CONTROL :
    (paddr == `IOC_ADDR_PIE) ? ioc_pkg::IOC_SEL_PIE :
    (paddr == `IOC_ADDR_PIR) ? ioc_pkg::IOC_SEL_PIR :
    (paddr == `IOC_ADDR_TIMER) ? ioc_pkg::IOC_SEL_TIMER :
    (paddr == `IOC_ADDR_PORT) ? ioc_pkg::IOC_SEL_PORT :
    ioc_pkg::IOC_SEL_NONE;

  // read data selection, unmapped reads return zero
  assign rd_mux_w =
    (sel_w == ioc_pkg::IOC_SEL_OPTION) ? 8'(opt_q) :
    (sel_w == ioc_pkg::IOC_SEL_CORE_INTERRUPT_CONTROL) ? 8'(intc_q) :
    (sel_w == ioc_pkg::IOC_SEL_PIE) ? pie_q :
    (sel_w == ioc_pkg::IOC_SEL_PIR) ? pir_q :
    (sel_w == ioc_pkg::IOC_SEL_TIMER) ? timer_q :
    (sel_w == ioc_pkg::IOC_SEL_PORT) ?
      {2'b00, sync_q[`IOC_PORT_MSB:`IOC_PORT_LSB]} :
    8'h00;

  // two-stage synchronisers for all pins: ext, timer clock, port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else if (ce) begin
      meta_q <= {ext_irq_pin, timer_clock_pin, port_pins};
      sync_q <= meta_q;
    end
  end

  // previous synchronised ext and timer pin levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 2'b00;
    end else if (ce) begin
      prev_q <= sync_q[`IOC_PIN_EXT:`IOC_PIN_TCK];
    end
  end

  // pin edges as chosen by the option bits
  assign ext_edge_w = ioc_edge(prev_q[1], sync_q[`IOC_PIN_EXT],
                               ~opt_q.ext_irq_edge_select);
  assign tck_edge_w = ioc_edge(prev_q[0], sync_q[`IOC_PIN_TCK],
                               opt_q.timer_source_edge);

  // timer source and shared prescaler routing
  assign tmr_src_w = opt_q.timer_clock_source ? tck_edge_w
                                              : instr_tick;
  assign presc_event_w = opt_q.prescaler_assign ? wdt_tick
                                                : tmr_src_w;
  assign presc_mask_w = ioc_rate_mask(opt_q.prescaler_rate,
                                      ~opt_q.prescaler_assign);
  assign presc_hit_w = presc_event_w &
                       ((presc_q & presc_mask_w) == presc_mask_w);
  assign tmr_inc_w = opt_q.prescaler_assign ? tmr_src_w
                                            : presc_hit_w;
  assign tmr_wr_w = wr_w & (sel_w == ioc_pkg::IOC_SEL_TIMER);
  assign rollover_w = tmr_inc_w & ~tmr_wr_w & (timer_q == 8'hff);

  // prescaler counter, counts events of whichever user owns it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 8'h00;
    end else if (ce && presc_event_w) begin
      presc_q <= presc_q + 8'h01;
    end
  end

  // timer count has no reset so it survives a device reset
  always_ff @(posedge pclk) begin
    if (ce && tmr_wr_w) begin
      timer_q <= pwdata[7:0];
    end else if (ce && tmr_inc_w) begin
      timer_q <= timer_q + 8'h01;
    end
  end

  // option and enable registers take software writes
  assign opt_d = (wr_w && sel_w == ioc_pkg::IOC_SEL_OPTION) ?
                 ioc_pkg::ioc_option_type'(pwdata[7:0]) : opt_q;
  assign pie_d = (wr_w && sel_w == ioc_pkg::IOC_SEL_PIE) ?
                 pwdata[7:0] : pie_q;
  assign intc_base_w = (wr_w && sel_w == ioc_pkg::IOC_SEL_CORE_INTERRUPT_CONTROL) ?
                       ioc_pkg::ioc_core_interrupt_control_type'(pwdata[7:0]) : intc_q;

  // pins differ from the values last read through the port register
  assign mismatch_w = sync_q[`IOC_PORT_MSB:`IOC_PORT_LSB] != last_read_q;

  // sticky core flags; a set in the clearing cycle wins
  always_comb begin
    intc_d = intc_base_w;
    intc_d.timer_overflow_flag = intc_base_w.timer_overflow_flag |
                                 rollover_w;
    intc_d.ext_irq_flag = intc_base_w.ext_irq_flag | ext_edge_w;
    intc_d.port_change_flag = intc_base_w.port_change_flag |
                              mismatch_w;
  end

  // peripheral request flags, set by the sources whatever the masks
  assign pir_d = ((wr_w && sel_w == ioc_pkg::IOC_SEL_PIR) ?
                  pwdata[7:0] : pir_q) | periph_set;

  // request toward the core
  assign core_req_w = (intc_q.timer_overflow_enable &
                       intc_q.timer_overflow_flag) |
                      (intc_q.ext_irq_enable & intc_q.ext_irq_flag) |
                      (intc_q.port_change_enable &
                       intc_q.port_change_flag);
  assign periph_req_w = intc_q.peripheral_irq_enable &
                        (|(pie_q & pir_q));
  assign irq_d = intc_q.global_irq_enable &
                 (core_req_w | periph_req_w);

  // control registers with their reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= ioc_pkg::ioc_option_type'(`IOC_OPTION_RESET);
      intc_q <= ioc_pkg::ioc_core_interrupt_control_type'(`IOC_CORE_INTERRUPT_CONTROL_RESET);
      pie_q <= `IOC_PIE_RESET;
      pir_q <= `IOC_PIR_RESET;
    end else if (ce) begin
      opt_q <= opt_d;
      intc_q <= intc_d;
      pie_q <= pie_d;
      pir_q <= pir_d;
    end
  end

  // read data captured in setup; a completed port read updates the
  // compare latch with the value software saw
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      last_read_q <= 6'h00;
    end else if (setup_w) begin
      prdata_q <= {24'h00_0000, rd_mux_w};
    end else if (access_w && !pwrite &&
                 sel_w == ioc_pkg::IOC_SEL_PORT) begin
      last_read_q <= prdata_q[5:0];
    end
  end

  // registered outputs: pull-ups, request, watchdog tick (divided only while the prescaler is assigned to it)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_q <= 6'h00;
      irq_q <= 1'b0;
      wdt_q <= 1'b0;
    end else if (ce) begin
      pullup_q <= opt_q.pullup_disable ? 6'h00 : port_latch;
      irq_q <= irq_d;
      wdt_q <= opt_q.prescaler_assign ? presc_hit_w : wdt_tick;
    end
  end

  assign prdata = prdata_q;
  assign pullup_en = pullup_q;
  assign irq_to_core = irq_q;
  assign wdt_prescaled_tick = wdt_q;
  assign timer_count = timer_q;

  // pull-ups follow latch or are forced off one cycle later
  AST_PULLUP: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> (pullup_en == ($past(opt_q.pullup_disable) ? 6'h00
                          : $past(port_latch))))
    else $error("pull-up output wrong for option and latch");

  // selected ext edge leaves the ext flag set
  AST_EXT_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ext_edge_w |=> intc_q.ext_irq_flag)
    else $error("ext edge did not set ext flag");

  // rising ext edge with falling selected must not be seen as an edge
  AST_EXT_SENSE: assert property (@(posedge pclk) disable iff (!presetn)
    ext_edge_w |-> (sync_q[`IOC_PIN_EXT] ==
                    opt_q.ext_irq_edge_select))
    else $error("ext edge detected on wrong polarity");

  // undivided internal tick advances the timer by one
  AST_INT_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !opt_q.timer_clock_source && opt_q.prescaler_assign &&
    instr_tick && !tmr_wr_w |=> timer_q == $past(timer_q) + 8'h01)
    else $error("instruction tick did not advance timer");

  // falling pin edge, when selected, advances an undivided timer
  AST_PIN_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    ce && opt_q.timer_clock_source && opt_q.prescaler_assign &&
    !tmr_wr_w && prev_q[0] && !sync_q[`IOC_PIN_TCK] &&
    opt_q.timer_source_edge |=> timer_q == $past(timer_q) + 8'h01)
    else $error("falling timer pin edge not counted");

  // prescaler on the timer at 1:8: only every eighth event advances it
  AST_PRESC_TMR: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !opt_q.prescaler_assign && opt_q.prescaler_rate == 3'b010 &&
    presc_event_w && !tmr_wr_w |=> timer_q == $past(timer_q) +
    ((($past(presc_q) & 8'h07) == 8'h07) ? 8'h01 : 8'h00))
    else $error("timer advanced off the 1:8 prescaler ratio");

  // watchdog rate 1:1 passes each tick through
  AST_WDT_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && opt_q.prescaler_assign && opt_q.prescaler_rate == 3'b000 &&
    wdt_tick |=> wdt_prescaled_tick)
    else $error("watchdog tick lost at rate 1:1");

  // no request while global enable is low
  AST_GIE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !intc_q.global_irq_enable |=> !irq_to_core)
    else $error("request raised with global enable low");

  // peripheral flags alone need the peripheral enable
  AST_PERIPHERAL_IRQ_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !intc_q.peripheral_irq_enable && !core_req_w |=>
    !irq_to_core)
    else $error("peripheral request passed peripheral gate");

  // an enabled flag under global enable raises the request
  AST_REQ: assert property (@(posedge pclk) disable iff (!presetn)
    ce && intc_q.global_irq_enable && intc_q.ext_irq_enable &&
    intc_q.ext_irq_flag |=> irq_to_core)
    else $error("enabled flag did not raise request");

  // rollover sets the overflow flag even with enables off
  AST_ROLL: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rollover_w |=> intc_q.timer_overflow_flag)
    else $error("rollover did not set overflow flag");

  // a set flag stays until software writes the register
  AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    intc_q.timer_overflow_flag &&
    !(wr_w && sel_w == ioc_pkg::IOC_SEL_CORE_INTERRUPT_CONTROL) |=>
    intc_q.timer_overflow_flag)
    else $error("overflow flag dropped without a write");

  // pins differing from the last read value set the port flag
  AST_PORT: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mismatch_w |=> intc_q.port_change_flag)
    else $error("port mismatch did not set port flag");

  // peripheral set pulses land in the request register
  AST_PIR: assert property (@(posedge pclk) disable iff (!presetn)
    ce && periph_set != 8'h00 |=>
    (pir_q & $past(periph_set)) == $past(periph_set))
    else $error("peripheral event lost");

endmodule : ioc_ctrl

// ==== ioc_src_model.sv ====
// ioc_src_model.sv: tick sources on the far side of the block
// assumes the bench asks for a burst of ticks with a one-cycle start
`timescale 1ns/1ps
module ioc_src_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // burst request from the bench
  input wire logic start,
  input wire logic [7:0] count,
  // tick pulses toward the block
  output logic instr_tick,
  output logic wdt_tick
);
  logic [7:0] left_q;
  logic [1:0] div_q;
  // one tick every fourth cycle, like an instruction clock at fosc/4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 8'h00;
      div_q <= 2'h0;
    end else if (start) begin
      left_q <= count;
      div_q <= 2'h0;
    end else if (left_q != 8'h00) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
  // both sources share the burst so the bench knows every count
  assign instr_tick = (left_q != 8'h00) && (div_q == 2'h3);
  assign wdt_tick = instr_tick;
endmodule : ioc_src_model

// ==== ioc_ctrl_tb_top.sv ====
// ioc_ctrl_tb_top.sv: self-checking bench for the interrupt and option block
// assumes ioc_ctrl, ioc_src_model and ioc_defs.svh; ce is held high except in the final freeze check
`timescale 1ns/1ps
`include "ioc_defs.svh"
module ioc_ctrl_tb_top;
  typedef struct packed {
    logic [7:0] ic;
    logic [7:0] pie;
    logic [7:0] set;
    logic irq;
  } ioc_row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq_to_core, wdt_prescaled_tick, err;
  logic ext_pin = 1'b0, tck_pin = 1'b0, start = 1'b0, ce = 1'b1;
  logic instr_tick, wdt_tick;
  logic [5:0] port_pins = 6'h00, port_latch = 6'h00, pullup_en;
  logic [7:0] periph_set = 8'h00, timer_count, count = 8'h00;
  int fail_count = 0, checks_done = 0, wdt_seen = 0;
  // gating cases: control, enables, pulses, expected request
  ioc_row_type rows [17] = '{
    '{8'hc0, 8'h80, 8'h80, 1'b1}, '{8'hc0, 8'h40, 8'h40, 1'b1},
    '{8'hc0, 8'h20, 8'h20, 1'b1}, '{8'hc0, 8'h10, 8'h10, 1'b1},
    '{8'hc0, 8'h08, 8'h08, 1'b1}, '{8'hc0, 8'h04, 8'h04, 1'b1},
    '{8'hc0, 8'h02, 8'h02, 1'b1}, '{8'hc0, 8'h01, 8'h01, 1'b1},
    '{8'h40, 8'h01, 8'h01, 1'b0}, '{8'h80, 8'h01, 8'h01, 1'b0},
    '{8'hc0, 8'h02, 8'h01, 1'b0}, '{8'ha4, 8'h00, 8'h00, 1'b1},
    '{8'h24, 8'h00, 8'h00, 1'b0}, '{8'h92, 8'h00, 8'h00, 1'b1},
    '{8'h89, 8'h00, 8'h00, 1'b1}, '{8'h88, 8'h00, 8'h00, 1'b0},
    '{8'hc0, 8'hff, 8'h00, 1'b0}};

  ioc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_pin), .timer_clock_pin(tck_pin),
    .port_pins(port_pins), .port_latch(port_latch), .pullup_en(pullup_en),
    .instr_tick(instr_tick), .wdt_tick(wdt_tick), .periph_set(periph_set),
    .irq_to_core(irq_to_core), .wdt_prescaled_tick(wdt_prescaled_tick),
    .timer_count(timer_count));
  ioc_src_model i_src (.pclk(pclk), .presetn(presetn), .start(start),
    .count(count), .instr_tick(instr_tick), .wdt_tick(wdt_tick));

  // 20 MHz clock
  always #25 pclk = ~pclk;
  // count prescaled watchdog ticks
  always @(posedge pclk) begin
    if (wdt_prescaled_tick === 1'b1) wdt_seen++;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, exp, input string what);
    apb(1'b0, a, 8'h00);
    chk(what, rd, 32'(exp));
  endtask : rchk
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask : waitc
  task automatic pulse(input logic [7:0] s);
    @(posedge pclk);
    periph_set <= s;
    @(posedge pclk);
    periph_set <= 8'h00;
  endtask : pulse
  task automatic fire(input logic [7:0] n);
    @(posedge pclk);
    start <= 1'b1;
    count <= n;
    @(posedge pclk);
    start <= 1'b0;
    waitc(4 * n + 4);
  endtask : fire
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // cut a hang short
  initial begin
    waitc(20000);
    fail_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    waitc(4);
    presetn <= 1'b1;
    rchk(`IOC_ADDR_OPTION, 8'hff, "option");
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00, "core_interrupt_control");
    rchk(`IOC_ADDR_PIE, 8'h00, "pie");
    rchk(`IOC_ADDR_PIR, 8'h00, "pir");
    foreach (rows[i]) begin
      apb(1'b1, `IOC_ADDR_PIR, 8'h00);
      apb(1'b1, `IOC_ADDR_CORE_INTERRUPT_CONTROL, rows[i].ic);
      apb(1'b1, `IOC_ADDR_PIE, rows[i].pie);
      pulse(rows[i].set);
      waitc(3);
      chk("irq", irq_to_core, 32'(rows[i].irq));
      rchk(`IOC_ADDR_PIR, rows[i].set, "pir");
      rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, rows[i].ic, "core_interrupt_control");
      rchk(`IOC_ADDR_PIE, rows[i].pie, "pie");
    end
    apb(1'b1, `IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00);
    apb(1'b1, 8'h18, 8'hff);
    chk("slverr", 32'(err), 32'h0000_0001);
    rchk(8'h18, 8'h00, "unmapped");
    // pull-ups follow the latch only while enabled
    port_latch <= 6'h2a;
    apb(1'b1, `IOC_ADDR_OPTION, 8'h7f);
    waitc(2);
    chk("pullup", 32'(pullup_en), 32'h0000_002a);
    apb(1'b1, `IOC_ADDR_OPTION, 8'hff);
    waitc(2);
    chk("pullup off", 32'(pullup_en), 32'h0000_0000);
    // external edge sense, rising then falling
    ext_pin <= 1'b1;
    waitc(6);
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h02, "ext rise");
    apb(1'b1, `IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00);
    ext_pin <= 1'b0;
    waitc(6);
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00, "ext fall off");
    apb(1'b1, `IOC_ADDR_OPTION, 8'hbf);
    ext_pin <= 1'b1;
    waitc(6);
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00, "ext rise off");
    ext_pin <= 1'b0;
    waitc(6);
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h02, "ext fall");
    apb(1'b1, `IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00);
    // timer on the pin, falling then rising edge
    apb(1'b1, `IOC_ADDR_TIMER, 8'h00);
    tck_pin <= 1'b1;
    waitc(6);
    rchk(`IOC_ADDR_TIMER, 8'h00, "tck rise");
    tck_pin <= 1'b0;
    waitc(6);
    rchk(`IOC_ADDR_TIMER, 8'h01, "tck fall");
    apb(1'b1, `IOC_ADDR_OPTION, 8'haf);
    tck_pin <= 1'b1;
    waitc(6);
    rchk(`IOC_ADDR_TIMER, 8'h02, "tck rise");
    tck_pin <= 1'b0;
    waitc(6);
    rchk(`IOC_ADDR_TIMER, 8'h02, "tck fall");
    // port change and compare latch
    port_pins <= 6'h08;
    waitc(6);
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h01, "port flag");
    rchk(`IOC_ADDR_PORT, 8'h08, "port");
    apb(1'b1, `IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00);
    waitc(6);
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00, "port clear");
    // reset in mid-run keeps the timer, re-arms the port flag
    apb(1'b1, `IOC_ADDR_TIMER, 8'h5a);
    presetn <= 1'b0;
    waitc(4);
    presetn <= 1'b1;
    waitc(6);
    rchk(`IOC_ADDR_TIMER, 8'h5a, "timer kept");
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h01, "port again");
    rchk(`IOC_ADDR_PORT, 8'h08, "port");
    apb(1'b1, `IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h00);
    // prescaler on the timer at 1:8, rollover sets the flag
    apb(1'b1, `IOC_ADDR_OPTION, 8'h02);
    apb(1'b1, `IOC_ADDR_TIMER, 8'hfe);
    wdt_seen = 0;
    fire(8'd16);
    rchk(`IOC_ADDR_TIMER, 8'h00, "timer div");
    rchk(`IOC_ADDR_CORE_INTERRUPT_CONTROL, 8'h04, "overflow");
    chk("wdt copy", 32'(wdt_seen), 32'h0000_0010);
    // prescaler on the watchdog, timer undivided
    apb(1'b1, `IOC_ADDR_OPTION, 8'h08);
    apb(1'b1, `IOC_ADDR_TIMER, 8'hf0);
    wdt_seen = 0;
    fire(8'd5);
    rchk(`IOC_ADDR_TIMER, 8'hf5, "timer 1:1");
    chk("wdt 1:1", 32'(wdt_seen), 32'h0000_0005);
    chk("timer out", 32'(timer_count), 32'h0000_00f5);
    // a low clock enable freezes the timer while ticks keep coming
    ce <= 1'b0;
    fire(8'd3);
    chk("frozen", 32'(timer_count), 32'h0000_00f5);
    ce <= 1'b1;
    rchk(`IOC_ADDR_TIMER, 8'hf5, "timer frozen");
    end_of_test();
  end
endmodule : ioc_ctrl_tb_top
